//--- wake_source_model.sv
// Purpose: far side: oscillator ticks and wake sources
// Assumes: ticks are one-cycle enables at fixed spacing
// Notes: wake lines follow the bench command, level
`timescale 1ns/1ns
module wake_source_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // command and outputs
    input wire logic [5:0] wake_cmd_i,
    output logic slow_rc_tick_o,
    output logic sub_tick_o,
    output logic [5:0] wake_req_o
);
    logic [3:0] div_ff;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_ff <= 4'h0;
            slow_rc_tick_o <= 1'b0;
            sub_tick_o <= 1'b0;
            wake_req_o <= 6'h00;
        end else begin
            div_ff <= div_ff + 4'h1;
            slow_rc_tick_o <= (div_ff[2:0] == 3'h4);
            sub_tick_o <= div_ff[0];
            wake_req_o <= wake_cmd_i;
        end
    end
endmodule : wake_source_model

//--- wakeup_gate_pkg.sv
// Purpose: constants for the wake-up regulator and watch gate sequencer
// Assumes: one 20 MHz clock; slow oscillator and sub clock arrive as tick enables
// Notes: mode codes are local to this block
package wakeup_gate_pkg;
    localparam int CLK_HZ = 20000000;
    // mode codes
    localparam int MODE_W = 4;
    localparam logic [3:0] MODE_RUN = 4'h0;
    localparam logic [3:0] MODE_SLEEP = 4'h1;
    localparam logic [3:0] MODE_PLL_TIMER = 4'h2;
    localparam logic [3:0] MODE_MAIN_TIMER = 4'h3;
    localparam logic [3:0] MODE_HSRC_TIMER = 4'h4;
    localparam logic [3:0] MODE_SUB_TIMER = 4'h5;
    localparam logic [3:0] MODE_SLOWRC_TIMER = 4'h6;
    localparam logic [3:0] MODE_STOP = 4'h7;
    // wake source bit positions
    localparam int SRC_NMI = 0;
    localparam int SRC_EXT = 1;
    localparam int SRC_WDOG = 2;
    localparam int SRC_USB = 3;
    localparam int SRC_WATCH = 4;
    localparam int SRC_LVD = 5;
    localparam int SRC_W = 6;
    // settle interval in slow oscillator periods, and its time figure
    localparam int SETTLE_TICKS = 35;
    localparam int SETTLE_US = 350;
    localparam int TICK_W = 6;
    localparam int WATCH_W = 32;
    localparam logic [5:0] TICK_ZERO = 6'h00;
endpackage : wakeup_gate_pkg

//--- wakeup_regulator_watch_gate.sv
// Purpose: regulator drive and watch counter gating on wake from slow timer modes
// Assumes: slow_internal_rc_osc and sub clock given as one-cycle tick enables
// Notes: watch counter is held here; lost periods are never corrected
//
// Behaviour
// - low-drive regulator in sub/slow-RC timer modes
// - wake interrupt: normal drive, wait stabilization
// - gate watch counter clock while stabilizing
// - lag equals 35 slow oscillator periods
// - no gating in other modes or stop
// - six wake sources trigger the gated return
// - reset-based exit clears the watch counter
`timescale 1ns/1ns
module wakeup_regulator_watch_gate #(
    parameter int SETTLE_PERIODS = wakeup_gate_pkg::SETTLE_TICKS,
    parameter int COUNT_W = wakeup_gate_pkg::WATCH_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // clock enables
    input wire logic slow_rc_tick_i,
    input wire logic sub_tick_i,
    // power mode and wake
    input wire logic [wakeup_gate_pkg::MODE_W-1:0] mode_i,
    input wire logic [wakeup_gate_pkg::SRC_W-1:0] wake_req_i,
    input wire logic standby_reset_i,
    // regulator and status
    output logic reg_low_drive_o,
    output logic settling_o,
    output logic resume_o,
    output logic watch_clk_en_o,
    output logic [COUNT_W-1:0] watch_count_o
);

    typedef enum logic [2:0] {
        ST_AWAKE = 3'h1,
        ST_LOWPWR = 3'h2,
        ST_SETTLE = 3'h4
    } seq_state_type;

    typedef struct packed {
        seq_state_type st;
        logic [wakeup_gate_pkg::TICK_W-1:0] ticks;
        logic [COUNT_W-1:0] count;
        logic resume;
    } state_type;

    state_type cur_ff;
    state_type nxt_cur;

    function automatic logic slow_timer_mode(input logic [wakeup_gate_pkg::MODE_W-1:0] m);
        slow_timer_mode = (m == wakeup_gate_pkg::MODE_SUB_TIMER) || (m == wakeup_gate_pkg::MODE_SLOWRC_TIMER);
    endfunction : slow_timer_mode

    function automatic logic settle_last(input logic [wakeup_gate_pkg::TICK_W-1:0] t);
        settle_last = (t == 6'(SETTLE_PERIODS - 1));
    endfunction : settle_last

    logic any_wake;
    logic gate;
    assign any_wake = |wake_req_i;

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.resume = 1'b0;
        gate = (cur_ff.st == ST_SETTLE);
        case (cur_ff.st)
            ST_AWAKE: begin
                if (slow_timer_mode(mode_i)) begin
                    nxt_cur.st = ST_LOWPWR;
                end
            end
            ST_LOWPWR: begin
                if (any_wake) begin
                    nxt_cur.st = ST_SETTLE;
                    nxt_cur.ticks = wakeup_gate_pkg::TICK_ZERO;
                end else if (!slow_timer_mode(mode_i)) begin
                    nxt_cur.st = ST_AWAKE;
                end
            end
            ST_SETTLE: begin
                if (slow_rc_tick_i) begin
                    if (settle_last(cur_ff.ticks)) begin
                        nxt_cur.st = ST_AWAKE;
                        nxt_cur.resume = 1'b1;
                    end else begin
                        nxt_cur.ticks = cur_ff.ticks + 6'h01;
                    end
                end
            end
            default: begin
                nxt_cur.st = ST_AWAKE;
            end
        endcase
        if (sub_tick_i && !gate) begin
            nxt_cur.count = cur_ff.count + 1'b1;
        end
        if (standby_reset_i) begin
            nxt_cur.count = '0;
            nxt_cur.st = ST_AWAKE;
            nxt_cur.resume = 1'b0;
            nxt_cur.ticks = wakeup_gate_pkg::TICK_ZERO;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cur_ff <= '{st: ST_AWAKE, ticks: wakeup_gate_pkg::TICK_ZERO, count: '0, resume: 1'b0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign reg_low_drive_o = (cur_ff.st == ST_LOWPWR);
    assign settling_o = (cur_ff.st == ST_SETTLE);
    assign resume_o = cur_ff.resume;
    assign watch_clk_en_o = (cur_ff.st != ST_SETTLE);
    assign watch_count_o = cur_ff.count;

    // assertions
    sequence wake_seen;
        cur_ff.st == ST_LOWPWR && any_wake && !standby_reset_i;
    endsequence

    sequence enter_low;
        cur_ff.st == ST_AWAKE && slow_timer_mode(mode_i) && !standby_reset_i;
    endsequence

    sequence other_mode;
        cur_ff.st == ST_AWAKE && !slow_timer_mode(mode_i);
    endsequence

    sequence mid_tick;
        settling_o && slow_rc_tick_i && !settle_last(cur_ff.ticks) && !standby_reset_i;
    endsequence

    sequence last_tick;
        settling_o && slow_rc_tick_i && settle_last(cur_ff.ticks) && !standby_reset_i;
    endsequence

    sequence back_awake;
        !settling_o && !reg_low_drive_o && watch_clk_en_o && resume_o;
    endsequence

    lowpwr_mode_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        reg_low_drive_o |-> slow_timer_mode($past(mode_i)) || $past(reg_low_drive_o))
        else $error("low drive outside slow timer mode");

    low_enter_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        enter_low |=> reg_low_drive_o && !settling_o)
        else $error("slow timer mode did not select low drive");

    low_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        reg_low_drive_o && !any_wake && slow_timer_mode(mode_i) && !standby_reset_i |=> reg_low_drive_o)
        else $error("low drive dropped without wake");

    wake_settle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        wake_seen |=> settling_o && !reg_low_drive_o)
        else $error("wake did not start settling");

    tick_zero_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        wake_seen |=> cur_ff.ticks == wakeup_gate_pkg::TICK_ZERO)
        else $error("settle count not restarted");

    settle_end_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        last_tick |=> back_awake)
        else $error("settle did not end after last tick");

    gate_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        settling_o && !standby_reset_i |=> $stable(watch_count_o) || !settling_o)
        else $error("watch counter moved while gated");

    settle_len_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        resume_o |-> $past(cur_ff.ticks) == 6'(SETTLE_PERIODS - 1))
        else $error("settle length wrong");

    tick_step_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        mid_tick |=> settling_o && cur_ff.ticks == $past(cur_ff.ticks) + 6'h01)
        else $error("slow tick not counted while settling");

    tick_wait_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        settling_o && !slow_rc_tick_i && !standby_reset_i |=> settling_o && $stable(cur_ff.ticks))
        else $error("settle count moved without slow tick");

    run_open_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !$past(settling_o) && !$past(reg_low_drive_o) |-> watch_clk_en_o)
        else $error("watch clock gated without low power state");

    other_mode_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        other_mode |=> !reg_low_drive_o && !settling_o && watch_clk_en_o)
        else $error("gating in a mode that must not gate");

    src_any_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        settling_o && !$past(settling_o) |-> $past(any_wake))
        else $error("settling without wake source");

    awake_ignore_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cur_ff.st == ST_AWAKE |=> !settling_o)
        else $error("settling started from awake state");

    reset_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        standby_reset_i |=> watch_count_o == '0)
        else $error("watch counter not cleared");

    reset_awake_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        standby_reset_i |=> !settling_o && !reg_low_drive_o && !resume_o)
        else $error("standby reset did not return to awake");

    resume_count_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        watch_clk_en_o && sub_tick_i && !standby_reset_i |=> watch_count_o == $past(watch_count_o) + 1'b1)
        else $error("count did not resume from held value");

    count_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !sub_tick_i && !standby_reset_i |=> $stable(watch_count_o))
        else $error("count moved without sub tick");

    resume_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        resume_o |=> !resume_o)
        else $error("resume pulse longer than one cycle");

endmodule : wakeup_regulator_watch_gate

//--- wakeup_regulator_watch_gate_test.sv
// Purpose: self-checking bench for the wake-up watch gate
// Assumes: settle interval at its default of 35 slow ticks
// Notes: queue holds the watch count expected at resume
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; $display("Error %s exp %0h got %0h", n, e, g); end end
module wakeup_regulator_watch_gate_test;
    localparam int SP = wakeup_gate_pkg::SETTLE_TICKS;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [3:0] mode = 4'h0;
    logic [5:0] cmd = 6'h00;
    logic sbr = 1'b0;
    logic slow_t, sub_t, low, settle, resume, clk_en;
    logic [5:0] wreq;
    logic [31:0] cnt, held, exp_cnt = 32'h0, rnd = 32'h2DCD;
    logic [31:0] note_q[$];
    logic [3:0] nm[6] = '{wakeup_gate_pkg::MODE_RUN, wakeup_gate_pkg::MODE_SLEEP, wakeup_gate_pkg::MODE_PLL_TIMER,
        wakeup_gate_pkg::MODE_MAIN_TIMER, wakeup_gate_pkg::MODE_HSRC_TIMER, wakeup_gate_pkg::MODE_STOP};
    int err_total = 0, samples_checked = 0, ticks = 0, k;
    always #25 clk_i = ~clk_i;
    wake_source_model far (.clk_i(clk_i), .rst_b_i(rst_b_i), .wake_cmd_i(cmd),
        .slow_rc_tick_o(slow_t), .sub_tick_o(sub_t), .wake_req_o(wreq));
    wakeup_regulator_watch_gate #(.SETTLE_PERIODS(SP)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .slow_rc_tick_i(slow_t), .sub_tick_i(sub_t), .mode_i(mode), .wake_req_i(wreq),
        .standby_reset_i(sbr), .reg_low_drive_o(low), .settling_o(settle), .resume_o(resume),
        .watch_clk_en_o(clk_en), .watch_count_o(cnt));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic test_done();
        if (err_total == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done
    // watcher: reference count, slow ticks while settling, held count at resume
    always @(negedge clk_i) begin
        if (!rst_b_i) begin
            exp_cnt = 32'h0;
            ticks = 0;
        end else begin
            `CHK("watch count", exp_cnt, cnt)
            if (settle && slow_t) ticks++;
            if (resume) begin
                `CHK("pending note", 1'b1, note_q.size() != 0)
                if (note_q.size() != 0) held = note_q.pop_front();
                `CHK("settle ticks", SP, ticks)
                `CHK("held count", held, cnt)
                ticks = 0;
            end
            if (sbr) exp_cnt = 32'h0;
            else if (sub_t && !settle) exp_cnt = exp_cnt + 32'h1;
        end
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(negedge clk_i);
        `CHK("clk en", 1'b1, clk_en)
        begin : scen
            for (int s = 0; s < 6; s++) begin
                @(posedge clk_i);
                mode <= s[0] ? wakeup_gate_pkg::MODE_SLOWRC_TIMER : wakeup_gate_pkg::MODE_SUB_TIMER;
                repeat (2) @(negedge clk_i);
                `CHK("low drive", 1'b1, low)
                @(posedge clk_i);
                cmd <= 6'h01 << s;
                k = 0;
                while (settle !== 1'b1 && k < 9) begin
                    @(negedge clk_i);
                    k++;
                end
                `CHK("settling", 1'b1, settle)
                `CHK("clk gated", 1'b0, clk_en)
                `CHK("normal drive", 1'b0, low)
                @(posedge clk_i);
                note_q.push_back(exp_cnt);
                mode <= wakeup_gate_pkg::MODE_RUN;
                cmd <= 6'h00;
                k = 0;
                while (resume !== 1'b1 && k < 400) begin
                    @(negedge clk_i);
                    k++;
                end
                if (k == 400) begin
                    err_total++;
                    disable scen;
                end
            end
            foreach (nm[i]) begin
                rnd = lfsr(rnd);
                @(posedge clk_i);
                mode <= nm[i];
                cmd <= rnd[5:0] | 6'h01;
                repeat (20) begin
                    @(negedge clk_i);
                    `CHK("no gating", 1'b1, clk_en)
                    `CHK("no settle", 1'b0, settle)
                    `CHK("no low drive", 1'b0, low)
                end
            end
            @(posedge clk_i);
            mode <= wakeup_gate_pkg::MODE_SUB_TIMER;
            cmd <= 6'h00;
            repeat (30) @(posedge clk_i);
            sbr <= 1'b1;
            @(posedge clk_i);
            sbr <= 1'b0;
            @(negedge clk_i);
            `CHK("cleared", 32'h0, cnt)
            `CHK("awake after reset", 1'b0, low)
        end
        test_done();
    end
endmodule : wakeup_regulator_watch_gate_test
